// >>> pkg/rmd_pkg.sv
package rmd_pkg;
	// Instruction word layout
	localparam int unsigned IW_W      = 14;
	localparam int unsigned DW        = 8;
	localparam int unsigned AW        = 7;
	localparam int unsigned DEST_BIT  = 7;
	// Opcode prefixes and fixed codes
	localparam logic [5:0]  OPC_MOVE_PFX   = 6'h08;   // bits 13:8 of file-to-dest move
	localparam logic [6:0]  OPC_STORE_PFX  = 7'h01;   // bits 13:7 of accumulator store
	localparam logic [13:0] OPC_OPTLOAD    = 14'h0062; // operand-free option load
	// Address of the option register in the file space
	localparam logic [6:0]  OPTION_ADDR    = 7'h01;
	// Reset values
	localparam logic [7:0]  ACC_RST        = 8'h00;
	localparam logic [7:0]  OPTION_RST     = 8'hff;
	localparam logic [7:0]  FILE_RST       = 8'h00;
	localparam int unsigned FILE_DEPTH     = 128;

	// Register state of the block
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] opt;
		logic       zero;
		logic       done;
	} rmd_state_s;
endpackage

// >>> core/rmd_core.sv
// What this block does
// - Decode file move, copy register to destination
// - Destination bit zero: accumulator; one: file
// - File move updates zero flag either way
// - Accumulator store writes file, flags unchanged
// - Option-load opcode copies accumulator to option
// - Option register also addressable as file register
`timescale 1ns/1ps
module rmd_core import rmd_pkg::*; (
	input  wire logic          i_mclk,   // Instruction clock, 20 MHz
	input  wire logic          i_nrst,   // Async reset, active low
	input  wire logic          i_valid,  // Instruction word present this cycle
	input  wire logic [13:0]   i_instr,  // Fetched program word
	output logic      [7:0]    o_acc,    // Accumulator
	output logic      [7:0]    o_option, // Option configuration register
	output logic               o_zero,   // Zero flag
	output logic               o_done    // Pulse: an instruction retired
);

	rmd_state_s st_r;                     // All scalar state
	rmd_state_s st_nxt;                   // Next value
	logic [7:0] file_r [0:FILE_DEPTH-1];  // General file registers

	// Decoder outputs
	logic       is_move;
	logic       is_store;
	logic       is_optld;
	logic       dest_file;
	logic [6:0] faddr;
	logic [7:0] rd_val;
	logic       file_we;
	logic [7:0] file_wd;

	// Field decode, pure combinational so no wait state is added
	always_comb begin
		is_move   = i_valid && (i_instr[13:8] == OPC_MOVE_PFX);
		is_store  = i_valid && (i_instr[13:7] == OPC_STORE_PFX);
		is_optld  = i_valid && (i_instr == OPC_OPTLOAD);
		dest_file = i_instr[DEST_BIT];
		faddr     = i_instr[6:0];
	end

	// Read port; option register is mapped into file space
	always_comb begin
		if (faddr == OPTION_ADDR) begin
			rd_val = st_r.opt;
		end else begin
			rd_val = file_r[faddr];
		end
	end

	// Next state for scalar registers
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		file_we     = 1'b0;
		file_wd     = rd_val;
		if (is_move) begin
			st_nxt.zero = (rd_val == 8'h00);
			st_nxt.done = 1'b1;
			if (dest_file) begin
				file_we = 1'b1;
				file_wd = rd_val;
			end else begin
				st_nxt.acc = rd_val;
			end
		end else if (is_store) begin
			// Flags untouched on purpose
			file_we     = 1'b1;
			file_wd     = st_r.acc;
			st_nxt.done = 1'b1;
		end else if (is_optld) begin
			st_nxt.opt  = st_r.acc;
			st_nxt.done = 1'b1;
		end
		// Writes to the option address land in the option register
		if (file_we && faddr == OPTION_ADDR) begin
			st_nxt.opt = file_wd;
		end
	end

	// Scalar state register
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= '{acc: ACC_RST, opt: OPTION_RST, zero: 1'b0, done: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// File array, no reset: would cost a large reset tree
	always_ff @(posedge i_mclk) begin
		if (file_we && faddr != OPTION_ADDR) begin
			file_r[faddr] <= file_wd;
		end
	end

	assign o_acc    = st_r.acc;
	assign o_option = st_r.opt;
	assign o_zero   = st_r.zero;
	assign o_done   = st_r.done;

	// Assertions
	sequence s_move_acc;
		i_valid && i_instr[13:8] == OPC_MOVE_PFX && !i_instr[DEST_BIT];
	endsequence

	sequence s_store;
		i_valid && i_instr[13:7] == OPC_STORE_PFX;
	endsequence

	AST_MOVE_TO_ACC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_move_acc |=> o_acc == $past(rd_val)) else $error("move to acc wrong");

	AST_MOVE_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		is_move |=> o_zero == ($past(rd_val) == 8'h00)) else $error("zero flag wrong");

	AST_STORE_FLAGS: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_store |=> $stable(o_zero) && $stable(o_acc)) else $error("store changed flags");

	AST_STORE_DATA: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_store ##1 (faddr == $past(faddr) && !i_valid) |-> rd_val == $past(o_acc))
		else $error("store data lost");

	AST_OPTLOAD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		is_optld |=> o_option == $past(o_acc) && $stable(o_zero)) else $error("option load wrong");

	AST_OPT_ADDR: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(s_store and (faddr == OPTION_ADDR)) |=> o_option == $past(o_acc)) else $error("option store wrong");

	AST_ONE_CYCLE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(is_move || is_store || is_optld) |=> o_done) else $error("not single cycle");

	AST_MOVE_FILE_KEEP: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(is_move && dest_file) |=> $stable(o_acc)) else $error("file move touched acc");

	// Further sequences for the checks below
	// A word that is offered but matches none of the three patterns
	sequence s_foreign;
		i_valid && !is_move && !is_store && !is_optld;
	endsequence

	// No word offered at all this edge
	sequence s_idle;
		!i_valid;
	endsequence

	// Move that reads the option register into the accumulator
	sequence s_move_opt_to_acc;
		is_move && !dest_file && (faddr == OPTION_ADDR);
	endsequence

	// Store, then at once a move of the same address back to the accumulator
	// Catches a write that lands late or in the wrong slot
	sequence s_store_readback;
		s_store ##1 (is_move && !dest_file && faddr == $past(faddr));
	endsequence

	// Refused encodings leave every visible register alone
	AST_FOREIGN_QUIET: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_foreign |=> !o_done && $stable(o_acc) && $stable(o_option) && $stable(o_zero))
		else $error("foreign word changed state");

	// An empty cycle is not an instruction
	AST_IDLE_QUIET: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_idle |=> !o_done && $stable(o_acc) && $stable(o_option) && $stable(o_zero))
		else $error("idle cycle changed state");

	// Retire pulse only ever follows a recognised word
	AST_DONE_CAUSE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		o_done |-> $past(is_move || is_store || is_optld))
		else $error("retire pulse without instruction");

	// Store to an ordinary address must not reach the option register
	AST_STORE_KEEP_OPT: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(s_store and (faddr != OPTION_ADDR)) |=> $stable(o_option))
		else $error("store hit option register");

	// Legacy load touches only the option register
	AST_OPTLOAD_ACC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		is_optld |=> $stable(o_acc)) else $error("option load changed acc");

	// A move never alters the option value, even when it targets it
	AST_MOVE_OPT_KEEP: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		is_move |=> $stable(o_option)) else $error("move changed option");

	// Reading the option address gives the option register itself
	AST_MOVE_OPT_READ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_move_opt_to_acc |=> o_acc == $past(o_option)) else $error("option read wrong");

	// Written value is visible to the very next instruction
	// No bypass is needed: the write lands on the edge that ends the store
	AST_STORE_READBACK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_store_readback |=> o_acc == $past(o_acc, 2)) else $error("stored value not read back");

	// Limitation: file slots other than the option address power up unknown;
	// software must write a slot before moving it, or the zero flag goes unknown.
	// The array has no reset on purpose, to keep the reset tree small.

	// Trade-off: decode is purely combinational from the offered word,
	// so the word must be settled well before the edge; in exchange no
	// instruction ever needs a second cycle.

endmodule

// >>> bench/rmd_core_test.sv
`timescale 1ns/1ps
module rmd_core_test import rmd_pkg::*;;
	logic        i_mclk;     // Instruction clock
	logic        i_nrst;     // Reset, active low
	logic        i_valid;    // Word present
	logic [13:0] i_instr;    // Program word
	logic [7:0]  o_acc;      // Accumulator
	logic [7:0]  o_option;   // Option register
	logic        o_zero;     // Zero flag
	logic        o_done;     // Retire pulse
	int          fails;      // Mismatches
	int          n_compared; // Comparisons

	rmd_core dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
		.o_acc(o_acc), .o_option(o_option), .o_zero(o_zero), .o_done(o_done));

	// 20 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// One comparison, counted
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Issue one word; checks land after the edge so the next word goes back to back
	task automatic step(logic [13:0] ins, logic v, logic [7:0] a, logic [7:0] o, logic z, logic d);
		i_valid <= v;
		i_instr <= ins;
		@(posedge i_mclk);
		fork
			begin
				#1;
				chk("acc", o_acc, a);
				chk("option", o_option, o);
				chk("zero", {7'h00, o_zero}, {7'h00, z});
				chk("done", {7'h00, o_done}, {7'h00, d});
			end
		join_none
	endtask

	// Foreign word and idle cycle change nothing
	task automatic t_refuse;
		step(14'h3fff, 1'b1, ACC_RST, OPTION_RST, 1'b0, 1'b0);
		step(14'h0801, 1'b0, ACC_RST, OPTION_RST, 1'b0, 1'b0);
		$display("refuse done");
	endtask

	// File 6 gets zero, file 5 gets option value; then moves both ways
	task automatic t_move;
		step(14'h0086, 1'b1, 8'h00, 8'hff, 1'b0, 1'b1);
		step(14'h0801, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		step(14'h0085, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		step(14'h0806, 1'b1, 8'h00, 8'hff, 1'b1, 1'b1);
		step(14'h0885, 1'b1, 8'h00, 8'hff, 1'b0, 1'b1);
		step(14'h0886, 1'b1, 8'h00, 8'hff, 1'b1, 1'b1);
		step(14'h0805, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		$display("move done");
	endtask

	// Legacy load, then store through the file address
	task automatic t_option;
		step(14'h0806, 1'b1, 8'h00, 8'hff, 1'b1, 1'b1);
		step(14'h0062, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1);
		step(14'h0805, 1'b1, 8'hff, 8'h00, 1'b0, 1'b1);
		step({7'h01, OPTION_ADDR}, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		step(14'h0081, 1'b0, 8'hff, 8'hff, 1'b0, 1'b0);
		step(14'h0081, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		step(14'h0801, 1'b1, 8'hff, 8'hff, 1'b0, 1'b1);
		step(14'h3fff, 1'b1, 8'hff, 8'hff, 1'b0, 1'b0);
		$display("option done");
	endtask

	// Verdict and end of run
	task automatic complete_run;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		#100000;
		fails++;
		complete_run();
	end

	// Main sequence
	initial begin
		fails = 0;
		n_compared = 0;
		i_nrst = 1'b0;
		i_valid = 1'b0;
		i_instr = 14'h0000;
		repeat (2) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_refuse();
		t_move();
		t_option();
		@(posedge i_mclk);
		#2;
		complete_run();
	end
endmodule
